/* File: sru_status_unit.sv */
// Purpose: Status byte, event registers, common commands and periodic trigger timer
// Assumes: Commands arrive decoded with a binary argument; same-clock inputs
// Notes: Reset models a power cycle and also sets the power-on event
//
// Function
// [RULE1] Clear-status empties operation and standard events
// [RULE2] Standard event enable mask writable and readable
// [RULE3] Event query returns standard event register
// [RULE4] Operation complete sets bit 0 when idle
// [RULE5] Completion query answers ASCII one when idle
// [RULE6] Ten slots save and recall instrument state
// [RULE7] Reset restores defaults, clears continuous, correction, keylock
// [RULE8] Host keeps service-enable bit 6 zero
// [RULE9] Status byte read by query or poll
// [RULE10] Summary bits 7,5,3; bits 2-0 zero
// [RULE11] Enabled status raises service request and bit 6
// [RULE12] Bit 4 follows unread output data
// [RULE13] Power-on bit until read; bits 6,1 zero
// [RULE14] Bit 5 on syntax error or mid-message trigger
// [RULE15] Bit 4 on out-of-range parameter
// [RULE16] Bit 3 on full error queue
// [RULE17] Bit 2 on empty read or lost data
// [RULE18] Bus trigger acts only with bus arm source
// [RULE19] Self-test returns sum of failing item codes
// [RULE20] Wait holds commands until prior ones finish
// [RULE21] Timer period 10 ms to 999 s, stepped
// [RULE22] Reset period follows integration mode
// [RULE23] Operation events latch falling; bits 8,9 rising (bit 9 never latches: SRU_OPER_VALID masks it off)
// [RULE24] Events stay until read; mask feeds summary
// [RULE25] Questionable group always zero
// [RULE26] Event register read clears; masked OR summary
`timescale 1ns/1ps
module sru_status_unit
    import sru_pkg::*;
#(
    parameter int MS_CYCLES = SRU_MS_CYCLES,
    parameter int STATE_W = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire sru_cmd_t cmd_code,
    input wire logic [SRU_ARG_W-1:0] cmd_arg,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [SRU_ARG_W-1:0] resp_data,
    input wire logic poll_req,
    output logic poll_valid,
    output logic [7:0] poll_data,
    output logic srq,
    input wire sru_err_t err_in,
    input wire logic outq_avail,
    input wire logic ops_busy,
    input wire logic [15:0] oper_cond,
    input wire logic get_in,
    input wire logic arm_src_bus,
    input wire sru_mode_t meas_mode,
    input wire logic [5:0] selftest_fail,
    input wire logic timer_run,
    output logic timer_tick,
    output logic bus_trigger,
    output logic cont_init,
    output logic corr_on,
    output logic klock_on,
    output logic inst_default,
    input wire logic [STATE_W-1:0] inst_state,
    output logic recall_valid,
    output logic [STATE_W-1:0] recall_state
);
    localparam logic [SRU_PRE_W-1:0] PRE_LAST = SRU_PRE_W'(MS_CYCLES - 1);

    sru_state_t q;
    sru_state_t next_q;

    logic take;
    logic [7:0] stb_now;
    logic [7:0] esr_set;
    logic [15:0] oper_set;
    logic [19:0] rst_period;
    logic slot_ok;
    logic slot_wr;
    logic slot_rd;

    // Period legal when in range and on its step grid
    function automatic logic period_ok(input logic [19:0] p);
        logic ok;
        ok = (p >= SRU_PER_MIN) && (p <= SRU_PER_MAX);
        if (p >= SRU_PER_MID_LIM) begin
            ok = ok && ((p % SRU_PER_COARSE_STEP) == 20'h00000);
        end else if (p >= SRU_PER_FINE_LIM) begin
            ok = ok && ((p % SRU_PER_MID_STEP) == 20'h00000);
        end
        return ok;
    endfunction : period_ok

    always_comb begin
        unique case (meas_mode)
            SRU_SHORT_INTEGRATION: rst_period = SRU_PER_SHORT; // [RULE22]
            SRU_MEDIUM_INTEGRATION: rst_period = SRU_PER_MEDIUM; // [RULE22]
            SRU_LONG_INTEGRATION: rst_period = SRU_PER_LONG; // [RULE22]
            default: rst_period = SRU_PER_SHORT;
        endcase
    end

    // Commands stall while a wait or completion query is outstanding
    assign cmd_ready = !q.waiting && !q.opcq_arm; // [RULE20]
    assign take = cmd_valid && cmd_ready;

    // Status byte assembled from summaries
    always_comb begin
        stb_now = 8'h00;
        stb_now[SRU_STB_OPER] = |(q.oper_ev & q.oper_en); // [RULE10] [RULE24]
        stb_now[SRU_STB_RQS] = q.service_request_flag; // [RULE11]
        stb_now[SRU_STB_ESB] = |(q.esr & q.ese); // [RULE10] [RULE26]
        stb_now[SRU_STB_MAV] = outq_avail; // [RULE12]
        stb_now[SRU_STB_QUES] = 1'b0; // [RULE25]
    end

    // Operation event transition filter
    always_comb begin
        oper_set = ((~oper_cond & q.cond_q & ~SRU_OPER_RISE) | (oper_cond & ~q.cond_q & SRU_OPER_RISE))
            & SRU_OPER_VALID; // [RULE23]
    end

    assign slot_ok = cmd_arg < SRU_ARG_W'(SRU_SLOTS);
    assign slot_wr = take && (cmd_code == SRU_CMD_SAV) && slot_ok; // [RULE6]
    assign slot_rd = take && (cmd_code == SRU_CMD_RCL) && slot_ok; // [RULE6]

    always_comb begin
        next_q = q;
        next_q.resp_valid = 1'b0;
        next_q.poll_valid = 1'b0;
        next_q.bus_trigger = 1'b0;
        next_q.timer_tick = 1'b0;
        next_q.inst_default = 1'b0;
        next_q.cond_q = oper_cond;

        esr_set = 8'h00;
        esr_set[SRU_ESR_CME] = err_in.syntax_err || err_in.get_mid_msg; // [RULE14]
        esr_set[SRU_ESR_EXE] = err_in.param_err; // [RULE15]
        esr_set[SRU_ESR_DDE] = err_in.err_queue_full; // [RULE16]
        esr_set[SRU_ESR_QYE] = err_in.read_empty || err_in.data_lost; // [RULE17]
        esr_set[SRU_ESR_OPC] = q.opc_arm && !ops_busy; // [RULE4]
        if (q.opc_arm && !ops_busy) begin
            next_q.opc_arm = 1'b0;
        end
        if (q.opcq_arm && !ops_busy) begin
            next_q.opcq_arm = 1'b0;
            next_q.resp_valid = 1'b1;
            next_q.resp_data = SRU_ARG_W'(SRU_ASCII_ONE); // [RULE5]
        end
        if (q.waiting && !ops_busy) begin
            next_q.waiting = 1'b0; // [RULE20]
        end
        if (get_in && arm_src_bus) begin
            next_q.bus_trigger = 1'b1; // [RULE18]
        end

        if (take) begin
            unique case (cmd_code)
                SRU_CMD_CLS: begin
                    next_q.esr = 8'h00; // [RULE1]
                    next_q.oper_ev = 16'h0000; // [RULE1]
                end
                SRU_CMD_ESE_SET: next_q.ese = cmd_arg[7:0]; // [RULE2]
                SRU_CMD_ESE_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(q.ese); // [RULE2]
                end
                SRU_CMD_ESR_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(q.esr); // [RULE3]
                    next_q.esr = 8'h00; // [RULE26] [RULE13]
                end
                SRU_CMD_OPC: next_q.opc_arm = 1'b1; // [RULE4]
                SRU_CMD_OPC_Q: next_q.opcq_arm = 1'b1; // [RULE5]
                SRU_CMD_RCL, SRU_CMD_SAV: begin
                    esr_set[SRU_ESR_EXE] = esr_set[SRU_ESR_EXE] || !slot_ok; // [RULE15]
                end
                SRU_CMD_RST: begin
                    next_q.inst_default = 1'b1; // [RULE7]
                    next_q.cont_init = 1'b0; // [RULE7]
                    next_q.corr_on = 1'b0; // [RULE7]
                    next_q.klock_on = 1'b0; // [RULE7]
                    next_q.period = rst_period; // [RULE22]
                    next_q.pre_cnt = '0;
                    next_q.ms_cnt = 20'h00000;
                end
                SRU_CMD_SRE_SET: next_q.sre = cmd_arg[7:0] & SRU_SRE_VALID; // [RULE8]
                SRU_CMD_SRE_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(q.sre);
                end
                SRU_CMD_STB_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(stb_now); // [RULE9]
                end
                SRU_CMD_TRG: next_q.bus_trigger = arm_src_bus; // [RULE18]
                SRU_CMD_TST_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(selftest_fail); // [RULE19]
                end
                SRU_CMD_WAI: next_q.waiting = ops_busy; // [RULE20]
                SRU_CMD_TIMER_SET: begin
                    if (period_ok(cmd_arg)) begin
                        next_q.period = cmd_arg; // [RULE21]
                        next_q.pre_cnt = '0;
                        next_q.ms_cnt = 20'h00000;
                    end else begin
                        esr_set[SRU_ESR_EXE] = 1'b1; // [RULE21]
                    end
                end
                SRU_CMD_TIMER_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = q.period;
                end
                SRU_CMD_OPER_EN_SET: next_q.oper_en = cmd_arg[15:0] & SRU_OPER_VALID; // [RULE24]
                SRU_CMD_OPER_EN_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(q.oper_en);
                end
                SRU_CMD_OPER_EV_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(q.oper_ev);
                    next_q.oper_ev = 16'h0000; // [RULE24]
                end
                SRU_CMD_OPER_COND_Q: begin
                    next_q.resp_valid = 1'b1;
                    next_q.resp_data = SRU_ARG_W'(oper_cond & SRU_OPER_VALID);
                end
                default: ;
            endcase
        end

        // New events win over a clear or read in the same cycle
        next_q.esr = (next_q.esr | esr_set) & SRU_ESR_VALID; // [RULE13] [RULE24]
        next_q.oper_ev = next_q.oper_ev | oper_set; // [RULE23] [RULE24]

        // Service request on a new enabled reason; a poll clears it
        next_q.any_en_q = |(stb_now & q.sre & SRU_SRE_VALID);
        next_q.service_request_flag = (next_q.any_en_q && !q.any_en_q) || (q.service_request_flag && !poll_req); // [RULE11]
        if (poll_req) begin
            next_q.poll_valid = 1'b1;
            next_q.poll_data = stb_now; // [RULE9]
        end

        // Periodic trigger timer in whole milliseconds
        if (timer_run && !(take && (cmd_code == SRU_CMD_TIMER_SET || cmd_code == SRU_CMD_RST))) begin
            if (q.pre_cnt == PRE_LAST) begin
                next_q.pre_cnt = '0;
                if (q.ms_cnt + 20'h00001 >= q.period) begin
                    next_q.ms_cnt = 20'h00000;
                    next_q.timer_tick = 1'b1; // [RULE21]
                end else begin
                    next_q.ms_cnt = q.ms_cnt + 20'h00001;
                end
            end else begin
                next_q.pre_cnt = q.pre_cnt + SRU_PRE_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '0;
            q.esr <= 8'h80; // [RULE13]
            q.period <= SRU_PER_SHORT;
        end else begin
            q <= next_q;
        end
    end

    sru_slot_mem #(
        .DEPTH(SRU_SLOTS),
        .WIDTH(STATE_W)
    ) u_slots (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(slot_wr),
        .wr_addr(cmd_arg[SRU_SLOT_AW-1:0]),
        .wr_data(inst_state),
        .rd_en(slot_rd),
        .rd_addr(cmd_arg[SRU_SLOT_AW-1:0]),
        .rd_valid(recall_valid),
        .rd_data(recall_state)
    );

    assign resp_valid = q.resp_valid;
    assign resp_data = q.resp_data;
    assign poll_valid = q.poll_valid;
    assign poll_data = q.poll_data;
    assign srq = q.service_request_flag; // [RULE11]
    assign timer_tick = q.timer_tick;
    assign bus_trigger = q.bus_trigger;
    assign cont_init = q.cont_init;
    assign corr_on = q.corr_on;
    assign klock_on = q.klock_on;
    assign inst_default = q.inst_default;
endmodule : sru_status_unit

/* File: sru_pkg.sv */
// Purpose: Shared constants and types of the status reporting unit
// Assumes: One clock at 200 MHz, synchronous active-high reset
// Notes: Register values are plain binary; decimal formatting is done downstream
package sru_pkg;

    // Clock and time base
    localparam int SRU_CLK_MHZ = 200;
    localparam int SRU_ONE_MS_US = 1000;
    localparam int SRU_MS_CYCLES = SRU_ONE_MS_US * SRU_CLK_MHZ;

    // Widths
    localparam int SRU_ARG_W = 20;
    localparam int SRU_PRE_W = 20;
    localparam int SRU_SLOTS = 10;
    localparam int SRU_SLOT_AW = 4;

    // Periodic trigger period, in ms
    localparam logic [19:0] SRU_PER_MIN = 20'h0000A;
    localparam logic [19:0] SRU_PER_MAX = 20'hF3E58;
    localparam logic [19:0] SRU_PER_FINE_LIM = 20'h02710;
    localparam logic [19:0] SRU_PER_MID_LIM = 20'h186A0;
    localparam logic [19:0] SRU_PER_MID_STEP = 20'h0000A;
    localparam logic [19:0] SRU_PER_COARSE_STEP = 20'h00064;
    localparam logic [19:0] SRU_PER_SHORT = 20'h0000A;
    localparam logic [19:0] SRU_PER_MEDIUM = 20'h0001E;
    localparam logic [19:0] SRU_PER_LONG = 20'h00190;

    // Status byte bits
    localparam int SRU_STB_OPER = 7;
    localparam int SRU_STB_RQS = 6;
    localparam int SRU_STB_ESB = 5;
    localparam int SRU_STB_MAV = 4;
    localparam int SRU_STB_QUES = 3;
    localparam logic [7:0] SRU_SRE_VALID = 8'hBF;

    // Standard event bits
    localparam int SRU_ESR_OPC = 0;
    localparam int SRU_ESR_QYE = 2;
    localparam int SRU_ESR_DDE = 3;
    localparam int SRU_ESR_EXE = 4;
    localparam int SRU_ESR_CME = 5;
    localparam int SRU_ESR_PON = 7;
    localparam logic [7:0] SRU_ESR_VALID = 8'hBD;

    // Operation status group
    localparam logic [15:0] SRU_OPER_VALID = 16'h01F7;
    localparam logic [15:0] SRU_OPER_RISE = 16'h0300;

    localparam logic [7:0] SRU_ASCII_ONE = 8'h31;

    typedef enum logic [4:0] {
        SRU_CMD_CLS, SRU_CMD_ESE_SET, SRU_CMD_ESE_Q, SRU_CMD_ESR_Q, SRU_CMD_OPC, SRU_CMD_OPC_Q,
        SRU_CMD_RCL, SRU_CMD_RST, SRU_CMD_SAV, SRU_CMD_SRE_SET, SRU_CMD_SRE_Q, SRU_CMD_STB_Q,
        SRU_CMD_TRG, SRU_CMD_TST_Q, SRU_CMD_WAI, SRU_CMD_TIMER_SET, SRU_CMD_TIMER_Q,
        SRU_CMD_OPER_EN_SET, SRU_CMD_OPER_EN_Q, SRU_CMD_OPER_EV_Q, SRU_CMD_OPER_COND_Q
    } sru_cmd_t;

    typedef enum logic [1:0] {
        SRU_SHORT_INTEGRATION, SRU_MEDIUM_INTEGRATION, SRU_LONG_INTEGRATION
    } sru_mode_t;

    // Error and event pulses from the command parser and output queue
    typedef struct packed {
        logic syntax_err;
        logic get_mid_msg;
        logic param_err;
        logic err_queue_full;
        logic read_empty;
        logic data_lost;
    } sru_err_t;

    typedef struct packed {
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] esr;
        logic [15:0] oper_en;
        logic [15:0] oper_ev;
        logic [15:0] cond_q;
        logic service_request_flag;
        logic any_en_q;
        logic opc_arm;
        logic opcq_arm;
        logic waiting;
        logic [19:0] period;
        logic [SRU_PRE_W-1:0] pre_cnt;
        logic [19:0] ms_cnt;
        logic cont_init;
        logic corr_on;
        logic klock_on;
        logic inst_default;
        logic resp_valid;
        logic [19:0] resp_data;
        logic poll_valid;
        logic [7:0] poll_data;
        logic bus_trigger;
        logic timer_tick;
    } sru_state_t;

endpackage : sru_pkg

/* File: sru_slot_mem.sv */
// Purpose: Storage slots for saved instrument states
// Assumes: One clock, registered read data
// Notes: Read data valid one cycle after the read request
`timescale 1ns/1ps
module sru_slot_mem
    import sru_pkg::*;
#(
    parameter int DEPTH = SRU_SLOTS,
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [SRU_SLOT_AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [SRU_SLOT_AW-1:0] rd_addr,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
        end
    end
endmodule : sru_slot_mem

/* File: sru_status_unit_chk.sv */
// Purpose: Port checks of the status reporting unit
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the design below
`timescale 1ns/1ps
module sru_status_unit_chk
    import sru_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire sru_cmd_t cmd_code,
    input wire logic [SRU_ARG_W-1:0] cmd_arg,
    input wire logic cmd_ready,
    input wire logic resp_valid,
    input wire logic [SRU_ARG_W-1:0] resp_data,
    input wire logic poll_valid,
    input wire logic [7:0] poll_data,
    input wire logic srq,
    input wire logic outq_avail,
    input wire logic ops_busy,
    input wire logic arm_src_bus,
    input wire logic [5:0] selftest_fail,
    input wire logic bus_trigger,
    input wire logic cont_init,
    input wire logic corr_on,
    input wire logic klock_on,
    input wire logic inst_default,
    input wire logic recall_valid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Command taken at this edge
    sequence s_take(sru_cmd_t c);
        cmd_valid && cmd_ready && cmd_code == c;
    endsequence

    // Wait or completion query still blocked
    sequence s_blocked(sru_cmd_t c);
        s_take(c) && ops_busy ##1 ops_busy;
    endsequence

    poll_low_zero_a: assert property (poll_valid |-> poll_data[3:0] == 4'h0)
        else $error("status byte low bits set");
    poll_mav_a: assert property (poll_valid |-> poll_data[SRU_STB_MAV] == $past(outq_avail))
        else $error("message bit wrong");
    poll_rqs_a: assert property (poll_valid |-> poll_data[SRU_STB_RQS] == $past(srq))
        else $error("request bit differs from srq");
    wait_hold_a: assert property (s_blocked(SRU_CMD_WAI) |-> !cmd_ready)
        else $error("command taken during wait");
    opcq_busy_a: assert property (s_blocked(SRU_CMD_OPC_Q) |-> !cmd_ready && !resp_valid)
        else $error("completion answered while busy");
    opcq_answer_a: assert property (s_take(SRU_CMD_OPC_Q) && !ops_busy |->
        ##[1:2] (resp_valid && resp_data == 20'h00031))
        else $error("completion answer missing");
    self_test_a: assert property (s_take(SRU_CMD_TST_Q) |=>
        resp_valid && resp_data == {14'h0, $past(selftest_fail)})
        else $error("self-test sum wrong");
    reset_cmd_a: assert property (s_take(SRU_CMD_RST) |=>
        inst_default && !cont_init && !corr_on && !klock_on)
        else $error("reset command effects missing");
    trig_on_a: assert property (s_take(SRU_CMD_TRG) && arm_src_bus |=> bus_trigger)
        else $error("bus trigger missing");
    trig_off_a: assert property (bus_trigger |-> $past(arm_src_bus))
        else $error("trigger without bus arm");
    event_read_a: assert property (s_take(SRU_CMD_ESR_Q) |=>
        resp_valid && resp_data[19:8] == 12'h000 && !resp_data[6] && !resp_data[1])
        else $error("event read answer malformed");
    recall_a: assert property (s_take(SRU_CMD_RCL) && cmd_arg < 20'h0000A |=> recall_valid)
        else $error("recall data missing");
endmodule : sru_status_unit_chk

bind sru_status_unit sru_status_unit_chk chk_u (.*);

/* File: sru_host_model.sv */
// Purpose: Bus controller issuing commands and serial polls
// Assumes: Same clock as the unit
// Notes: Argument lines scrambled while idle
`timescale 1ns/1ps
module sru_host_model
    import sru_pkg::*;
(
    input wire logic clk_sys,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output sru_cmd_t cmd_code,
    output logic [SRU_ARG_W-1:0] cmd_arg,
    output logic poll_req
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = SRU_CMD_STB_Q;
        cmd_arg = 20'h5A5A5;
        poll_req = 1'b0;
    end

    // Offer a command, hold it until taken
    task automatic issue(input sru_cmd_t code, input logic [SRU_ARG_W-1:0] arg, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_arg <= (code == SRU_CMD_SRE_SET) ? (arg & 20'hFFFBF) : arg;
        #1;
        while (!cmd_ready) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_arg <= ~arg;
    endtask : issue

    task automatic poll();
        @(posedge clk_sys);
        poll_req <= 1'b1;
        @(posedge clk_sys);
        poll_req <= 1'b0;
    endtask : poll
endmodule : sru_host_model

/* File: tb.sv */
// Purpose: Self-checking bench of the status reporting unit
// Assumes: Timer scaled to 4 cycles per ms
// Notes: Answers checked against queued expectations
`timescale 1ns/1ps
module tb
    import sru_pkg::*;
;
    logic clk_sys, reset, cmd_valid, cmd_ready, resp_valid, poll_req, poll_valid, srq, outq_avail, ops_busy;
    logic get_in, arm_src_bus, timer_run, timer_tick, bus_trigger, cont_init, corr_on, klock_on;
    logic inst_default, recall_valid;
    sru_cmd_t cmd_code;
    sru_mode_t meas_mode;
    sru_err_t err_in;
    logic [19:0] cmd_arg, resp_data;
    logic [7:0] poll_data;
    logic [5:0] selftest_fail;
    logic [15:0] oper_cond;
    logic [31:0] inst_state, recall_state, rnd;
    logic [19:0] exp_resp[$];
    logic [7:0] exp_poll[$];
    logic [31:0] exp_rec[$];
    logic [19:0] per_tab[3] = '{20'h0000A, 20'h0001E, 20'h00190};
    logic [7:0] err_w[6] = '{8'h04, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20};
    int error_cnt = 0;
    int cmp_count = 0;
    int trig_cnt = 0;

    sru_status_unit #(.MS_CYCLES(4)) dut_u (.*);
    sru_host_model host_u (.*);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic note(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : note
    task automatic cmp_resp(input logic [19:0] g, input logic [19:0] e);
        note(g === e, "query answer");
    endtask : cmp_resp
    task automatic cmp_poll(input logic [7:0] g, input logic [7:0] e);
        note(g === e, "poll byte");
    endtask : cmp_poll
    task automatic cmp_rec(input logic [31:0] g, input logic [31:0] e);
        note(g === e, "recalled state");
    endtask : cmp_rec
    task automatic cmp_lvl(input logic g, input logic e);
        note(g === e, "level output");
    endtask : cmp_lvl

    task automatic q(input sru_cmd_t c, input logic [19:0] a, input logic [19:0] e);
        exp_resp.push_back(e);
        rnd = xs(rnd);
        host_u.issue(c, a, int'(rnd[1:0]));
    endtask : q
    task automatic cmd(input sru_cmd_t c, input logic [19:0] a);
        host_u.issue(c, a, 0);
    endtask : cmd
    task automatic pulse_err(input logic [5:0] e);
        @(posedge clk_sys);
        err_in <= sru_err_t'(e);
        @(posedge clk_sys);
        err_in <= '0;
    endtask : pulse_err

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (resp_valid === 1'b1) begin
            if (exp_resp.size() > 0) cmp_resp(resp_data, exp_resp.pop_front());
            else note(1'b0, "unexpected answer");
        end
        if (poll_valid === 1'b1) begin
            if (exp_poll.size() > 0) cmp_poll(poll_data, exp_poll.pop_front());
            else note(1'b0, "unexpected poll");
        end
        if (recall_valid === 1'b1) begin
            if (exp_rec.size() > 0) cmp_rec(recall_state, exp_rec.pop_front());
            else note(1'b0, "unexpected recall");
        end
        if (bus_trigger === 1'b1) trig_cnt++;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end

    initial begin
        rnd = 32'h0000003C;
        {reset, outq_avail, ops_busy, get_in, arm_src_bus, timer_run} = 6'h20;
        err_in = '0;
        oper_cond = 16'h0000;
        meas_mode = SRU_SHORT_INTEGRATION;
        selftest_fail = 6'h00;
        inst_state = 32'h0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00080);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00000);
        for (int i = 0; i < 3; i++) begin
            rnd = xs(rnd);
            cmd(SRU_CMD_ESE_SET, {12'h000, rnd[7:0]});
            q(SRU_CMD_ESE_Q, 20'h0, {12'h000, rnd[7:0]});
        end
        for (int i = 0; i < 6; i++) begin
            pulse_err(6'h01 << i);
            q(SRU_CMD_ESR_Q, 20'h0, {12'h000, err_w[i]});
        end
        pulse_err(6'h08);
        cmd(SRU_CMD_CLS, 20'h0);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00000);
        oper_cond <= 16'h0001;
        repeat (2) @(posedge clk_sys);
        oper_cond <= 16'h0100;
        q(SRU_CMD_OPER_EV_Q, 20'h0, 20'h00101);
        q(SRU_CMD_OPER_EV_Q, 20'h0, 20'h00000);
        q(SRU_CMD_OPER_COND_Q, 20'h0, 20'h00100);
        outq_avail <= 1'b1;
        cmd(SRU_CMD_ESE_SET, 20'h00010);
        cmd(SRU_CMD_SRE_SET, 20'h00060);
        q(SRU_CMD_SRE_Q, 20'h0, 20'h00020);
        pulse_err(6'h08);
        repeat (3) @(posedge clk_sys);
        cmp_lvl(srq, 1'b1);
        exp_poll.push_back(8'h70);
        host_u.poll();
        repeat (3) @(posedge clk_sys);
        cmp_lvl(srq, 1'b0);
        outq_avail <= 1'b0;
        q(SRU_CMD_STB_Q, 20'h0, 20'h00020);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00010);
        cmd(SRU_CMD_OPER_EN_SET, 20'h00100);
        q(SRU_CMD_OPER_EN_Q, 20'h0, 20'h00100);
        oper_cond <= 16'h0000;
        repeat (2) @(posedge clk_sys);
        oper_cond <= 16'h0100;
        q(SRU_CMD_STB_Q, 20'h0, 20'h00080);
        cmd(SRU_CMD_OPER_EN_SET, 20'h0);
        ops_busy <= 1'b1;
        q(SRU_CMD_OPC_Q, 20'h0, 20'h00031);
        repeat (5) @(posedge clk_sys);
        ops_busy <= 1'b0;
        @(posedge clk_sys);
        ops_busy <= 1'b1;
        cmd(SRU_CMD_WAI, 20'h0);
        repeat (3) @(posedge clk_sys);
        cmp_lvl(cmd_ready, 1'b0);
        ops_busy <= 1'b0;
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00000);
        q(SRU_CMD_OPC_Q, 20'h0, 20'h00031);
        cmd(SRU_CMD_OPC, 20'h0);
        repeat (2) @(posedge clk_sys);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00001);
        for (int i = 0; i < 3; i++) begin
            rnd = xs(rnd);
            selftest_fail <= (i == 0) ? 6'h00 : rnd[5:0];
            q(SRU_CMD_TST_Q, 20'h0, {14'h0, (i == 0) ? 6'h00 : rnd[5:0]});
        end
        inst_state <= rnd;
        cmd(SRU_CMD_SAV, 20'h00009);
        inst_state <= ~rnd;
        exp_rec.push_back(rnd);
        cmd(SRU_CMD_RCL, 20'h00009);
        cmd(SRU_CMD_SAV, 20'h0000A);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00010);
        cmd(SRU_CMD_TIMER_SET, 20'h02710);
        q(SRU_CMD_TIMER_Q, 20'h0, 20'h02710);
        cmd(SRU_CMD_TIMER_SET, 20'h00009);
        q(SRU_CMD_ESR_Q, 20'h0, 20'h00010);
        for (int m = 0; m < 3; m++) begin
            meas_mode <= sru_mode_t'(m);
            cmd(SRU_CMD_RST, 20'h0);
            q(SRU_CMD_TIMER_Q, 20'h0, per_tab[m]);
        end
        cmd(SRU_CMD_TIMER_SET, 20'h0000A);
        timer_run <= 1'b1;
        repeat (41) @(negedge clk_sys);
        cmp_lvl(timer_tick, 1'b1);
        cmd(SRU_CMD_TRG, 20'h0);
        arm_src_bus <= 1'b1;
        cmd(SRU_CMD_TRG, 20'h0);
        @(posedge clk_sys);
        get_in <= 1'b1;
        @(posedge clk_sys);
        get_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmp_lvl(trig_cnt == 2, 1'b1);
        note(exp_resp.size() == 0 && exp_poll.size() == 0 && exp_rec.size() == 0, "answers missing");
        final_report();
    end
endmodule : tb
